// ### rtl/atc_core.sv
// Counting core with repetition gating and six input capture channels
//
// Contract
// - Edge mode with direction bit set counts the main counter down.
// - Starting in down mode loads the reload value, then decrements.
// - Reaching zero downward gives a one-cycle underflow pulse.
// - After underflow counter reloads and underflow flag sets; irq only when enabled.
// - Writing 0 to the underflow clear bit clears the underflow flag.
// - Center mode counts 0 up to reload, overflow, down to 0, underflow, repeat.
// - Center mode direction bit is read-only hardware state, cleared on entry.
// - Stopped or unbuffered, a reload write takes effect at once.
// - Running and buffered, a reload write waits for the next update event.
// - Starting the timer loads the repetition count into the repetition counter.
// - Repetition counter decrements on overflow/underflow unless the matching skip bit is set.
// - Nonzero repeat count: update only when counter reaches zero; zero count: always.
// - Software update request updates at once and reloads the repetition counter.
// - Three external channels, each with A and B buffered compare/capture registers.
// - Fourth channel is internal, single compare register, never captures.
// - Capture select bit 1 puts a channel in capture, in any counting mode.
// - Soft capture bit latches the counter at once on a channel in capture mode, and reads back cleared.
// - Edge code: 00 off, 01 rising, 10 falling, 11 both.
// - Capture sets channel flag; irq and dma requests follow their enables.
// - Capture while channel flag is set also sets overcapture flag.
// - Writing 0 to a channel clear bit clears that capture or overcapture flag.
// - Capture edges are served even while the timer is stopped.
// - Update event moves buffered values to active copies and clears prescaler count.
`timescale 1ns/100ps
`default_nettype none

module atc_core
  import atc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // APB slave
  input  wire atc_apb_req_s        apb_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Capture pins
  input  wire logic [ATC_NCH-1:0]  cap_pin_i,
  // Requests and events
  output logic                     irq_o,
  output logic [ATC_NCH-1:0]       dma_req_o,
  output logic                     overflow_pulse_o,
  output logic                     underflow_pulse_o,
  output logic                     update_event_o,
  output logic [ATC_NCMP-1:0]      cmp_match_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 en_reg, center_reg, dir_reg, bufen_reg;
  logic                 undie_reg, ovie_reg, uie_reg;
  logic [ATC_PRS_W-1:0] prs_reg, psc_cnt_reg;
  logic [CNT_W-1:0]     cnt_reg, arr_buf_reg, arr_act_reg;
  logic [ATC_REP_W-1:0] rep_cnt_reg, rep_val_reg;
  logic                 skip_up_reg, skip_dn_reg;
  logic                 ovf_reg, underflow_flag_reg, uif_reg;
  logic [ATC_NCH-1:0]   capf_reg, ovcf_reg;
  logic [ATC_CF_W-1:0]  cfg_reg [ATC_NCH];
  logic [CNT_W-1:0]     ccr_buf_reg [ATC_NCMP];
  logic [CNT_W-1:0]     ccr_act_reg [ATC_NCMP];
  logic [ATC_NCH-1:0]   pin_s1_reg, pin_s2_reg, pin_s3_reg;

  logic                 access, wr_fire, tick, ctr_ov, ctr_und, rep_dec;
  logic                 ctr_uev, ug, uev_now, start, ctrl_wr, nonempty;
  logic [ATC_NCH-1:0]   rise, fall, cap;
  logic [31:0]          rd_mux;
  logic                 addr_ok;

  // Word select helper
  function automatic logic hit(input logic [ATC_AW-1:0] a, input logic [ATC_AW-1:0] off);
    hit = (a == off);
  endfunction

  // Buffered write: effective at once when stopped or unbuffered
  function automatic logic direct_load(input logic running, input logic buffered);
    direct_load = ~running | ~buffered;
  endfunction

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  assign access  = apb_i.psel & apb_i.penable;
  assign wr_fire = access & pready_o & apb_i.pwrite & addr_ok;

  // Ready rises one cycle into the access phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~addr_ok;
      if (access & ~pready_o & ~apb_i.pwrite) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // Read decode and map check
  always_comb begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (apb_i.paddr)
      ATC_OFF_CTRL: begin
        rd_mux[ATC_CTRL_EN]     = en_reg;
        rd_mux[ATC_CTRL_DIR]    = dir_reg;
        rd_mux[ATC_CTRL_CENTER] = center_reg;
        rd_mux[ATC_CTRL_BUFEN]  = bufen_reg;
        rd_mux[ATC_CTRL_UNDIE]  = undie_reg;
        rd_mux[ATC_CTRL_OVIE]   = ovie_reg;
        rd_mux[ATC_CTRL_UIE]    = uie_reg;
        rd_mux[ATC_CTRL_PRS +: ATC_PRS_W] = prs_reg;
      end
      ATC_OFF_ARR: rd_mux[CNT_W-1:0] = arr_buf_reg;
      ATC_OFF_CNT: rd_mux[CNT_W-1:0] = cnt_reg;
      ATC_OFF_REP: begin
        rd_mux[ATC_REP_W-1:0]  = rep_val_reg;
        rd_mux[ATC_REP_SKIPUP] = skip_up_reg;
        rd_mux[ATC_REP_SKIPDN] = skip_dn_reg;
      end
      ATC_OFF_STAT: begin
        rd_mux[ATC_ST_OVF]  = ovf_reg;
        rd_mux[ATC_ST_UNDERFLOW_FLAG] = underflow_flag_reg;
        rd_mux[ATC_ST_UIF]  = uif_reg;
        rd_mux[ATC_ST_CAPF +: ATC_NCH] = capf_reg;
        rd_mux[ATC_ST_OVCF +: ATC_NCH] = ovcf_reg;
      end
      ATC_OFF_CLR, ATC_OFF_EVT: rd_mux = 32'h0000_0000;  // Write-only, soft bits read cleared
      default: begin
        addr_ok = 1'b0;
        for (int p = 0; p < ATC_NCH / 2; p++) begin
          if (hit(apb_i.paddr, ATC_OFF_CHCFG + ATC_AW'(4 * p))) begin
            rd_mux[2*ATC_CF_W-1:0] = {cfg_reg[2*p+1], cfg_reg[2*p]};
            addr_ok = 1'b1;
          end
        end
        for (int k = 0; k < ATC_NCMP; k++) begin
          if (hit(apb_i.paddr, ATC_OFF_CCR + ATC_AW'(4 * k))) begin
            rd_mux[CNT_W-1:0] = ccr_buf_reg[k];
            addr_ok = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign ctrl_wr = wr_fire & hit(apb_i.paddr, ATC_OFF_CTRL);
  assign start   = ctrl_wr & ~en_reg & apb_i.pwdata[ATC_CTRL_EN];
  assign ug      = wr_fire & hit(apb_i.paddr, ATC_OFF_EVT) & apb_i.pwdata[ATC_EVT_UG];
  assign tick    = en_reg & (psc_cnt_reg == prs_reg);
  // Overflow at top, underflow at zero
  assign ctr_ov  = tick & ~dir_reg & (cnt_reg >= arr_act_reg);
  assign ctr_und = tick & dir_reg & (cnt_reg == '0);
  assign rep_dec = (ctr_ov & ~skip_up_reg) | (ctr_und & ~skip_dn_reg);
  // Update only when repetition counter is at zero or steps down to zero
  assign nonempty = (rep_cnt_reg != '0);
  assign ctr_uev = (ctr_ov | ctr_und) & (~nonempty | (rep_dec & (rep_cnt_reg == ATC_REP_W'(1))));
  assign uev_now = ctr_uev | ug;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Mode, enables and prescaler setting
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg     <= 1'b0;
      center_reg <= 1'b0;
      bufen_reg  <= 1'b0;
      undie_reg  <= 1'b0;
      ovie_reg   <= 1'b0;
      uie_reg    <= 1'b0;
      prs_reg    <= '0;
    end else if (ctrl_wr) begin
      en_reg     <= apb_i.pwdata[ATC_CTRL_EN];
      center_reg <= apb_i.pwdata[ATC_CTRL_CENTER];
      bufen_reg  <= apb_i.pwdata[ATC_CTRL_BUFEN];
      undie_reg  <= apb_i.pwdata[ATC_CTRL_UNDIE];
      ovie_reg   <= apb_i.pwdata[ATC_CTRL_OVIE];
      uie_reg    <= apb_i.pwdata[ATC_CTRL_UIE];
      prs_reg    <= apb_i.pwdata[ATC_CTRL_PRS +: ATC_PRS_W];
    end
  end

  // Prescaler count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psc_cnt_reg <= '0;
    end else if (uev_now | ~en_reg | tick) begin
      psc_cnt_reg <= '0;
    end else begin
      psc_cnt_reg <= psc_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Main counter and direction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      dir_reg <= 1'b0;
    end else if (ctrl_wr) begin
      // Cleared on entering center mode, otherwise not writable there
      if (apb_i.pwdata[ATC_CTRL_CENTER] & ~center_reg) begin
        dir_reg <= 1'b0;
      end else if (~apb_i.pwdata[ATC_CTRL_CENTER]) begin
        dir_reg <= apb_i.pwdata[ATC_CTRL_DIR];
      end
      // Down start loads the reload value
      if (start & ~apb_i.pwdata[ATC_CTRL_CENTER] & apb_i.pwdata[ATC_CTRL_DIR]) begin
        cnt_reg <= arr_act_reg;
      end
    end else if (wr_fire & hit(apb_i.paddr, ATC_OFF_CNT)) begin
      cnt_reg <= apb_i.pwdata[CNT_W-1:0];
    end else if (ug) begin
      if (center_reg) begin
        dir_reg <= ~dir_reg;
      end else begin
        cnt_reg <= dir_reg ? arr_act_reg : '0;
      end
    end else if (tick) begin
      if (center_reg) begin
        // Turn round at the top and at zero
        if (ctr_ov) begin
          dir_reg <= 1'b1;
          cnt_reg <= (cnt_reg == '0) ? '0 : cnt_reg - 1'b1;
        end else if (ctr_und) begin
          dir_reg <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
        end else begin
          cnt_reg <= dir_reg ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
        end
      end else if (dir_reg) begin
        cnt_reg <= ctr_und ? arr_act_reg : cnt_reg - 1'b1;
      end else begin
        cnt_reg <= ctr_ov ? '0 : cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reload value
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arr_buf_reg <= '1;
      arr_act_reg <= '1;
    end else if (wr_fire & hit(apb_i.paddr, ATC_OFF_ARR)) begin
      arr_buf_reg <= apb_i.pwdata[CNT_W-1:0];
      if (direct_load(en_reg, bufen_reg)) begin
        arr_act_reg <= apb_i.pwdata[CNT_W-1:0];
      end
    end else if (uev_now) begin
      arr_act_reg <= arr_buf_reg;
    end
  end

  // ----------------------------------------------------------------
  // Repetition counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rep_val_reg <= '0;
      skip_up_reg <= 1'b0;
      skip_dn_reg <= 1'b0;
    end else if (wr_fire & hit(apb_i.paddr, ATC_OFF_REP)) begin
      rep_val_reg <= apb_i.pwdata[ATC_REP_W-1:0];
      skip_up_reg <= apb_i.pwdata[ATC_REP_SKIPUP];
      skip_dn_reg <= apb_i.pwdata[ATC_REP_SKIPDN];
    end
  end

  // Count, reload on start, on software update and at zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rep_cnt_reg <= '0;
    // Start loads; update request reloads at once
    end else if (start | ug) begin
      rep_cnt_reg <= rep_val_reg;
    // Reload when the update comes from the counter
    end else if (ctr_uev) begin
      rep_cnt_reg <= rep_val_reg;
    end else if (rep_dec) begin
      rep_cnt_reg <= rep_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter flags and event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg  <= 1'b0;
      underflow_flag_reg <= 1'b0;
      uif_reg  <= 1'b0;
    end else begin
      // Write of 0 clears, a new event wins
      if (wr_fire & hit(apb_i.paddr, ATC_OFF_CLR)) begin
        if (~apb_i.pwdata[ATC_ST_OVF])  ovf_reg  <= 1'b0;
        if (~apb_i.pwdata[ATC_ST_UNDERFLOW_FLAG]) underflow_flag_reg <= 1'b0;
        if (~apb_i.pwdata[ATC_ST_UIF])  uif_reg  <= 1'b0;
      end
      if (ctr_ov)  ovf_reg  <= 1'b1;
      // Underflow flag set with the reload
      if (ctr_und) underflow_flag_reg <= 1'b1;
      if (uev_now) uif_reg  <= 1'b1;
    end
  end

  // One-cycle pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overflow_pulse_o  <= 1'b0;
      underflow_pulse_o <= 1'b0;
      update_event_o    <= 1'b0;
    end else begin
      overflow_pulse_o  <= ctr_ov;
      underflow_pulse_o <= ctr_und;
      update_event_o    <= uev_now;
    end
  end

  // ----------------------------------------------------------------
  // Capture inputs
  // ----------------------------------------------------------------
  // Two-stage synchroniser, third stage for edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= cap_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign rise = pin_s2_reg & ~pin_s3_reg;
  assign fall = ~pin_s2_reg & pin_s3_reg;

  // Capture strobes, running or not
  always_comb begin
    for (int c = 0; c < ATC_NCH; c++) begin
      // Edge code picks edges, in any mode
      cap[c] = cfg_reg[c][ATC_CF_CS] &
               ((cfg_reg[c][ATC_CF_EDGE] & rise[c]) |
                (cfg_reg[c][ATC_CF_EDGE+1] & fall[c]) |
                (wr_fire & hit(apb_i.paddr, ATC_OFF_EVT) & apb_i.pwdata[ATC_EVT_SOFT+c]));
    end
  end

  // Channel configuration, pairs A and B per word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < ATC_NCH; c++) cfg_reg[c] <= '0;
    end else begin
      for (int p = 0; p < ATC_NCH / 2; p++) begin
        if (wr_fire & hit(apb_i.paddr, ATC_OFF_CHCFG + ATC_AW'(4 * p))) begin
          cfg_reg[2*p]   <= apb_i.pwdata[ATC_CF_W-1:0];
          cfg_reg[2*p+1] <= apb_i.pwdata[2*ATC_CF_W-1:ATC_CF_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare/capture registers
  // ----------------------------------------------------------------
  // Six buffered pin channels; index 6 compares only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < ATC_NCMP; k++) begin
        ccr_buf_reg[k] <= '0;
        ccr_act_reg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < ATC_NCMP; k++) begin
        if (k < ATC_NCH && cap[k % ATC_NCH]) begin
          ccr_buf_reg[k] <= cnt_reg;
        end else if (wr_fire & hit(apb_i.paddr, ATC_OFF_CCR + ATC_AW'(4 * k))) begin
          ccr_buf_reg[k] <= apb_i.pwdata[CNT_W-1:0];
          if (direct_load(en_reg, (k < ATC_NCH) ? cfg_reg[k % ATC_NCH][ATC_CF_BUFE] : bufen_reg)) begin
            ccr_act_reg[k] <= apb_i.pwdata[CNT_W-1:0];
          end
        end else if (uev_now) begin
          ccr_act_reg[k] <= ccr_buf_reg[k];
        end
      end
    end
  end

  // Compare match levels for compare-mode units
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_match_o <= '0;
    end else begin
      for (int k = 0; k < ATC_NCMP; k++) begin
        cmp_match_o[k] <= (cnt_reg == ccr_act_reg[k]) &
                          ((k >= ATC_NCH) || !cfg_reg[k % ATC_NCH][ATC_CF_CS]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture flags and requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      capf_reg  <= '0;
      ovcf_reg  <= '0;
      dma_req_o <= '0;
    end else begin
      for (int c = 0; c < ATC_NCH; c++) begin
        // Write of 0 clears, set wins
        if (wr_fire & hit(apb_i.paddr, ATC_OFF_CLR)) begin
          if (~apb_i.pwdata[ATC_ST_CAPF+c]) capf_reg[c] <= 1'b0;
          if (~apb_i.pwdata[ATC_ST_OVCF+c]) ovcf_reg[c] <= 1'b0;
        end
        if (cap[c]) capf_reg[c] <= 1'b1;
        if (cap[c] & capf_reg[c]) ovcf_reg[c] <= 1'b1;
        dma_req_o[c] <= cap[c] & cfg_reg[c][ATC_CF_DE];
      end
    end
  end

  // Combined interrupt request level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= 1'b0;
      if ((underflow_flag_reg & undie_reg) | (ovf_reg & ovie_reg) | (uif_reg & uie_reg)) irq_o <= 1'b1;
      for (int c = 0; c < ATC_NCH; c++) begin
        if (capf_reg[c] & cfg_reg[c][ATC_CF_IE]) irq_o <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### inc/atc_pkg.sv
// Constants and carrier types for the timer counting and capture core
package atc_pkg;

  // ----------------------------------------------------------------
  // Bus carrier
  // ----------------------------------------------------------------
  localparam int ATC_AW = 12;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ATC_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } atc_apb_req_s;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ATC_AW-1:0] ATC_OFF_CTRL   = 12'h000;
  localparam logic [ATC_AW-1:0] ATC_OFF_ARR    = 12'h004;
  localparam logic [ATC_AW-1:0] ATC_OFF_CNT    = 12'h008;
  localparam logic [ATC_AW-1:0] ATC_OFF_REP    = 12'h00c;
  localparam logic [ATC_AW-1:0] ATC_OFF_STAT   = 12'h010;
  localparam logic [ATC_AW-1:0] ATC_OFF_CLR    = 12'h014;
  localparam logic [ATC_AW-1:0] ATC_OFF_EVT    = 12'h018;
  localparam logic [ATC_AW-1:0] ATC_OFF_CHCFG  = 12'h01c;  // Three words, one per channel pair
  localparam logic [ATC_AW-1:0] ATC_OFF_CCR    = 12'h028;  // Seven words, index 6 is internal channel
  localparam int                ATC_NCH        = 6;        // Capture capable channels
  localparam int                ATC_NCMP       = 7;        // All compare units

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int ATC_CTRL_EN     = 0;
  localparam int ATC_CTRL_DIR    = 1;
  localparam int ATC_CTRL_CENTER = 2;
  localparam int ATC_CTRL_BUFEN  = 3;
  localparam int ATC_CTRL_UNDIE  = 4;
  localparam int ATC_CTRL_OVIE   = 5;
  localparam int ATC_CTRL_UIE    = 6;
  localparam int ATC_CTRL_PRS    = 8;
  localparam int ATC_PRS_W       = 8;

  // Repetition word fields
  localparam int ATC_REP_W       = 8;
  localparam int ATC_REP_SKIPUP  = 8;
  localparam int ATC_REP_SKIPDN  = 9;

  // Status word fields
  localparam int ATC_ST_OVF      = 0;
  localparam int ATC_ST_UNDERFLOW_FLAG     = 1;
  localparam int ATC_ST_UIF      = 2;
  localparam int ATC_ST_CAPF     = 8;
  localparam int ATC_ST_OVCF     = 16;

  // Event word fields
  localparam int ATC_EVT_UG      = 0;
  localparam int ATC_EVT_SOFT    = 8;

  // Per channel config byte, A in low byte, B in next byte
  localparam int ATC_CF_CS       = 0;
  localparam int ATC_CF_EDGE     = 1;
  localparam int ATC_CF_IE       = 3;
  localparam int ATC_CF_DE       = 4;
  localparam int ATC_CF_BUFE     = 5;
  localparam int ATC_CF_W        = 8;

endpackage

// ### verification/atc_core_sva.sv
// Port assertions for the counting and capture core
`timescale 1ns/100ps
`default_nettype none
module atc_core_sva
  import atc_pkg::*;
(
  // Clock, reset and bus
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire atc_apb_req_s       apb_i,
  input wire logic               pready_o,
  // Events and requests
  input wire logic               irq_o,
  input wire logic [ATC_NCH-1:0] dma_req_o,
  input wire logic               overflow_pulse_o,
  input wire logic               underflow_pulse_o,
  input wire logic               update_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_und_one: assert property (underflow_pulse_o |=> !underflow_pulse_o)
    else $error("underflow pulse too long");
  chk_ovf_one: assert property (overflow_pulse_o |=> !overflow_pulse_o)
    else $error("overflow pulse too long");
  chk_dir_excl: assert property (!(overflow_pulse_o && underflow_pulse_o))
    else $error("overflow and underflow together");
  chk_uev_one: assert property (update_event_o |=> !update_event_o)
    else $error("update pulse too long");
  chk_dma_one: assert property ((dma_req_o & $past(dma_req_o)) == '0)
    else $error("dma request longer than one cycle");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(pready_o && apb_i.pwrite, 2))
    else $error("irq dropped without a write");
  chk_rdy_wait: assert property (pready_o |-> apb_i.penable && $past(apb_i.penable))
    else $error("ready outside second access cycle");
  chk_rdy_one: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  cover property (underflow_pulse_o);
  cover property (overflow_pulse_o);
  cover property (update_event_o);
  cover property (|dma_req_o);
endmodule
bind atc_core atc_core_sva u_sva (.clk_i, .rst_i, .apb_i, .pready_o, .irq_o, .dma_req_o,
  .overflow_pulse_o, .underflow_pulse_o, .update_event_o);
`default_nettype wire

// ### verification/atc_pin_src.sv
// Capture pin source that follows levels commanded by the bench
`timescale 1ns/100ps
`default_nettype none
module atc_pin_src (
  // Clock and command
  input  wire logic       clk_i,
  input  wire logic [5:0] lvl_i,
  // Capture pins
  output var logic  [5:0] pin_o = 6'h00
);
  // edges move just after the clock
  always @(posedge clk_i) begin
    pin_o <= lvl_i;
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the counting and capture core
`timescale 1ns/100ps
`default_nettype none
module testbench
  import atc_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  atc_apb_req_s apb   = '0;
  logic [5:0]   lvl   = 6'h00;
  logic [5:0]   pins, dma;
  logic [31:0]  prdata_o, q, c1;
  logic         pready_o, pslverr_o, irq_o, ovf, underflow_pulse, update_event, e, d0;
  int           mismatches = 0;
  int           n_tests    = 0;
  int           n, m;
  assign d0 = dma[0];
  // Clock
  always #2 clk_i = ~clk_i;
  atc_pin_src u_pins (.clk_i, .lvl_i(lvl), .pin_o(pins));
  atc_core #(.CNT_W(16)) uut (.clk_i, .rst_i, .apb_i(apb), .prdata_o, .pready_o, .pslverr_o,
    .cap_pin_i(pins), .irq_o, .dma_req_o(dma), .overflow_pulse_o(ovf), .underflow_pulse_o(underflow_pulse),
    .update_event_o(update_event), .cmp_match_o());
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // Counts underflows until s is seen high, bounded
  task automatic till(ref logic s);
    m = 0;
    n = 0;
    do begin
      @(posedge clk_i);
      m += int'(underflow_pulse);
      n++;
    end while (s !== 1'b1 && n < 200);
    if (n >= 200) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // One APB transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    till(pready_o);
    q = prdata_o;
    e = pslverr_o;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(0, ATC_OFF_ARR, 0);
    chk(q, 32'h0000ffff);
    xfer(0, 12'h100, 0);
    chk({q[30:0], e}, 32'h1);
    xfer(1, ATC_OFF_ARR, 32'h20);
    xfer(0, ATC_OFF_ARR, 0);
    chk(q, 32'h20);
    xfer(1, ATC_OFF_CTRL, 32'h13);
    xfer(0, ATC_OFF_CNT, 0);
    c1 = q;
    xfer(0, ATC_OFF_CNT, 0);
    chk(c1 - q, 32'h4);
    chk({31'h0, c1 <= 32'h20 && c1 >= 32'h18}, 32'h1);
    till(underflow_pulse);
    xfer(0, ATC_OFF_STAT, 0);
    chk({q[ATC_ST_UNDERFLOW_FLAG], irq_o}, 32'h3);
    xfer(1, ATC_OFF_CTRL, 32'h10);
    xfer(1, ATC_OFF_CLR, ~(32'h1 << ATC_ST_UNDERFLOW_FLAG));
    xfer(0, ATC_OFF_STAT, 0);
    chk({q[ATC_ST_UNDERFLOW_FLAG], irq_o}, 32'h0);
    xfer(1, ATC_OFF_ARR, 32'h3);
    xfer(1, ATC_OFF_REP, 32'h2);
    xfer(1, ATC_OFF_CTRL, 32'h3);
    till(update_event);
    till(update_event);
    chk(m, 2);
    xfer(1, ATC_OFF_REP, 32'h202);
    m = 0;
    repeat (40) @(posedge clk_i) m += int'(update_event);
    chk(m, 0);
    xfer(1, ATC_OFF_EVT, 32'h1);
    m = 0;
    repeat (8) @(posedge clk_i) m += int'(update_event);
    chk(m, 1);
    xfer(1, ATC_OFF_CTRL, 32'h5);
    till(ovf);
    till(underflow_pulse);
    chk(n, 3);
    xfer(1, ATC_OFF_CTRL, 32'h0);
    xfer(1, ATC_OFF_CNT, 32'h1234);
    for (int c = 0; c < 4; c++) begin
      xfer(1, ATC_OFF_CHCFG, 32'h19 | (c << 1));
      m = 0;
      for (int i = 0; i < 24; i++) begin
        @(posedge clk_i);
        lvl <= {5'h0, i < 12};
        m += int'(d0);
      end
      chk(m, (c + 1) / 2);
    end
    xfer(0, ATC_OFF_STAT, 0);
    chk({q[ATC_ST_OVCF], q[ATC_ST_CAPF], irq_o}, 32'h7);
    xfer(0, ATC_OFF_CCR, 0);
    chk(q, 32'h1234);
    xfer(1, ATC_OFF_CLR, ~32'h10100);
    xfer(0, ATC_OFF_STAT, 0);
    chk(q & 32'h10100, 32'h0);
    xfer(1, ATC_OFF_CNT, 32'h55);
    xfer(1, ATC_OFF_EVT, 32'h100);
    xfer(0, ATC_OFF_CCR, 0);
    chk(q, 32'h55);
    xfer(0, ATC_OFF_EVT, 0);
    chk(q, 32'h0);
    xfer(1, ATC_OFF_CHCFG, 32'h0);
    xfer(1, ATC_OFF_CNT, 32'h66);
    xfer(1, ATC_OFF_EVT, 32'h100);
    xfer(0, ATC_OFF_CCR, 0);
    chk(q, 32'h55);
    xfer(1, ATC_OFF_CCR + 12'h018, 32'h77);
    xfer(1, ATC_OFF_CHCFG + 12'h008, 32'h100);
    xfer(1, ATC_OFF_EVT, 32'h6000);
    xfer(0, ATC_OFF_CCR + 12'h014, 0);
    chk(q, 32'h66);
    xfer(0, ATC_OFF_CCR + 12'h018, 0);
    chk(q, 32'h77);
    xfer(1, ATC_OFF_CTRL, 32'h6);
    xfer(1, ATC_OFF_CTRL, 32'h6);
    xfer(0, ATC_OFF_CTRL, 0);
    chk(q & 32'h6, 32'h4);
    xfer(1, ATC_OFF_REP, 32'h102);
    xfer(1, ATC_OFF_CTRL, 32'h9);
    xfer(1, ATC_OFF_ARR, 32'h40);
    till(ovf);
    till(ovf);
    chk(n, 4);
    xfer(1, ATC_OFF_EVT, 32'h1);
    till(ovf);
    till(ovf);
    chk(n, 32'h41);
    report_and_stop();
  end
endmodule
`default_nettype wire
